// >>> core/eidx_pkg.sv
// Package for the encoder index event configuration block.
// Assumes a 10 MHz system clock and a plain strobe register port.
package eidx_pkg;

  // Register offsets (word index on the plain port).
  localparam logic [7:0]  EIDX_CFG_OFS       = 8'h07;
  localparam logic [7:0]  EIDX_RESET_VAL_OFS = 8'h10;
  localparam logic [7:0]  EIDX_POS_OFS       = 8'h11;
  localparam logic [7:0]  EIDX_LATCH_OFS     = 8'h12;
  localparam logic [7:0]  EIDX_STATUS_OFS    = 8'h13;

  // Reset values.
  localparam logic [31:0] EIDX_CFG_RST       = 32'h0000_0400;
  localparam logic [31:0] EIDX_ZERO32        = 32'h0000_0000;

  // Field positions in encoder_input_config.
  localparam int EIDX_B_DECIMAL   = 0;
  localparam int EIDX_B_CLEAR     = 1;
  localparam int EIDX_B_CONT      = 2;
  localparam int EIDX_B_ONCE      = 3;
  localparam int EIDX_B_POL       = 4;
  localparam int EIDX_B_SENS_LO   = 5;
  localparam int EIDX_B_A_LVL     = 7;
  localparam int EIDX_B_B_LVL     = 8;
  localparam int EIDX_B_IGNORE_AB = 9;
  localparam int EIDX_B_LATCH     = 10;

  // Index sensitivity modes.
  typedef enum logic [1:0] {
    EIDX_SENS_LEVEL = 2'h0,
    EIDX_SENS_RISE  = 2'h1,
    EIDX_SENS_FALL  = 2'h2,
    EIDX_SENS_BOTH  = 2'h3
  } eidx_sens_t;

  // Decoded view of the configuration register.
  typedef struct packed {
    logic       latch_en;
    logic       ignore_ab;
    logic       b_level;
    logic       a_level;
    eidx_sens_t index_sensitivity;
    logic       pol_high;
    logic       once;
    logic       cont;
    logic       clear_en;
    logic       decimal;
  } eidx_cfg_t;

  // Register bus request carrier.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } eidx_req_t;

endpackage : eidx_pkg

// >>> core/eidx_sync.sv
// Two-flop synchroniser bank for the encoder A, B and index pins.
// Assumes inputs may be asynchronous to clk_i.
`timescale 1ns/1ps
module eidx_sync
  import eidx_pkg::*;
#(
  parameter int WIDTH = 3
)(
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  // Pins in, synchronised out.
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // The first stage feeds only the second stage.
  always_comb
  begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  // Register both stages per bit.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clk_i)
      begin
        if (!reset_n_i)
        begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end
        else
        begin
          meta_r[g] <= meta_nxt[g];
          sync_r[g] <= sync_nxt[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_r;

endmodule // eidx_sync

// >>> core/eidx_top.sv
// Index channel configuration and qualification for an ABN encoder input.
// Assumes a 10 MHz clock, synchronous active-low reset and a strobe register port.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module eidx_top
  import eidx_pkg::*;
#(
  parameter int POS_W = 32
)(
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  // Register port.
  input  wire logic [7:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [31:0]      rdata_o,
  // Encoder pins.
  input  wire logic             enc_a_i,
  input  wire logic             enc_b_i,
  input  wire logic             enc_n_i,
  // Position counter interface.
  input  wire logic [POS_W-1:0] enc_pos_i,
  output logic                  pos_load_o,
  output logic      [POS_W-1:0] pos_load_val_o,
  output logic                  index_event_o,
  output logic                  decimal_mode_o
);

  eidx_req_t        req;
  eidx_cfg_t        cfg;
  logic [2:0]       pins_sync;
  logic             a_s;
  logic             b_s;
  logic             n_s;

  logic [31:0]      cfg_r;
  logic [31:0]      cfg_nxt;
  logic [POS_W-1:0] rst_val_r;
  logic [POS_W-1:0] rst_val_nxt;
  logic [POS_W-1:0] latch_r;
  logic [POS_W-1:0] latch_nxt;
  logic [31:0]      rdata_r;
  logic [31:0]      rdata_nxt;
  logic             n_prev_r;
  logic             n_prev_nxt;
  logic             load_r;
  logic             load_nxt;
  logic [POS_W-1:0] load_val_r;
  logic [POS_W-1:0] load_val_nxt;
  logic             evt_r;
  logic             evt_nxt;
  logic             dec_r;
  logic             dec_nxt;

  logic             n_active;
  logic             n_rise_act;
  logic             n_fall_act;
  logic             raw_evt;
  logic             ab_ok;
  logic             qual_evt;
  logic             act_evt;

  // Bundle the bus signals.
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // Pins cross into the clock domain before any decision is made.
  eidx_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({enc_n_i, enc_b_i, enc_a_i}),
    .sync_o    (pins_sync)
  );

  assign a_s = pins_sync[0];
  assign b_s = pins_sync[1];
  assign n_s = pins_sync[2];

  // Decode the configuration fields.
  always_comb
  begin
    cfg.decimal           = cfg_r[EIDX_B_DECIMAL];
    cfg.clear_en          = cfg_r[EIDX_B_CLEAR];
    cfg.cont              = cfg_r[EIDX_B_CONT];
    cfg.once              = cfg_r[EIDX_B_ONCE];
    cfg.pol_high          = cfg_r[EIDX_B_POL];
    cfg.index_sensitivity = eidx_sens_t'(cfg_r[EIDX_B_SENS_LO +: 2]);
    cfg.a_level           = cfg_r[EIDX_B_A_LVL];
    cfg.b_level           = cfg_r[EIDX_B_B_LVL];
    cfg.ignore_ab         = cfg_r[EIDX_B_IGNORE_AB];
    cfg.latch_en          = cfg_r[EIDX_B_LATCH];
  end

  // Index qualification. Level mode fires every cycle the index stays active.
  always_comb
  begin
    n_active   = (n_s == cfg.pol_high);
    n_rise_act = n_active && (n_prev_r != cfg.pol_high);
    n_fall_act = !n_active && (n_prev_r == cfg.pol_high);
    unique case (cfg.index_sensitivity)
      EIDX_SENS_LEVEL: raw_evt = n_active;
      EIDX_SENS_RISE:  raw_evt = n_rise_act;
      EIDX_SENS_FALL:  raw_evt = n_fall_act;
      EIDX_SENS_BOTH:  raw_evt = n_rise_act || n_fall_act;
    endcase
    ab_ok    = cfg.ignore_ab || ((a_s == cfg.a_level) && (b_s == cfg.b_level));
    qual_evt = raw_evt && ab_ok;
    act_evt  = qual_evt && (cfg.cont || cfg.once);
  end

  // Register file, one-shot self clear and latch capture.
  always_comb
  begin
    cfg_nxt     = cfg_r;
    rst_val_nxt = rst_val_r;
    latch_nxt   = latch_r;
    if (req.wr && (req.addr == EIDX_CFG_OFS))
    begin
      cfg_nxt = req.wdata;
    end
    if (req.wr && (req.addr == EIDX_RESET_VAL_OFS))
    begin
      rst_val_nxt = req.wdata[POS_W-1:0];
    end
    // The hardware clear wins over a simultaneous config write only while cont is clear; with cont set, the write wins.
    if (act_evt && cfg.once && !cfg.cont)
    begin
      cfg_nxt[EIDX_B_ONCE] = 1'b0;
    end
    else if (act_evt && cfg.once && !(req.wr && (req.addr == EIDX_CFG_OFS)))
    begin
      cfg_nxt[EIDX_B_ONCE] = 1'b0;
    end
    if (act_evt && cfg.latch_en)
    begin
      latch_nxt = enc_pos_i;
    end
  end

  // Outputs toward the position counter and read-back path.
  always_comb
  begin
    n_prev_nxt   = n_s;
    load_nxt     = act_evt && cfg.clear_en;
    load_val_nxt = rst_val_r;
    evt_nxt      = qual_evt;
    dec_nxt      = cfg.decimal;
    rdata_nxt    = EIDX_ZERO32;
    if (req.rd)
    begin
      unique case (req.addr)
        EIDX_CFG_OFS:       rdata_nxt = cfg_r;
        EIDX_RESET_VAL_OFS: rdata_nxt = 32'(rst_val_r);
        EIDX_POS_OFS:       rdata_nxt = 32'(enc_pos_i);
        EIDX_LATCH_OFS:     rdata_nxt = 32'(latch_r);
        EIDX_STATUS_OFS:    rdata_nxt = {29'h0, n_s, b_s, a_s};
        default:            rdata_nxt = EIDX_ZERO32;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      cfg_r      <= EIDX_CFG_RST;
      rst_val_r  <= '0;
      latch_r    <= '0;
      rdata_r    <= EIDX_ZERO32;
      n_prev_r   <= 1'b0;
      load_r     <= 1'b0;
      load_val_r <= '0;
      evt_r      <= 1'b0;
      dec_r      <= 1'b0;
    end
    else
    begin
      cfg_r      <= cfg_nxt;
      rst_val_r  <= rst_val_nxt;
      latch_r    <= latch_nxt;
      rdata_r    <= rdata_nxt;
      n_prev_r   <= n_prev_nxt;
      load_r     <= load_nxt;
      load_val_r <= load_val_nxt;
      evt_r      <= evt_nxt;
      dec_r      <= dec_nxt;
    end
  end

  assign rdata_o        = rdata_r;
  assign pos_load_o     = load_r;
  assign pos_load_val_o = load_val_r;
  assign index_event_o  = evt_r;
  assign decimal_mode_o = dec_r;

  // Checks on the decimal output, synchroniser, qualification and action paths.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // The output only follows the bit once the cycle before was out of reset.
  decimal_follows_a: assert property ($past(reset_n_i) |-> decimal_mode_o == $past(cfg_r[EIDX_B_DECIMAL]))
    else $error("decimal output does not follow config bit 0");
  load_needs_clear_a: assert property (pos_load_o |-> $past(cfg_r[EIDX_B_CLEAR]))
    else $error("position load without clear enable");
  load_on_event_a: assert property ((act_evt && cfg.clear_en) |=> (pos_load_o && pos_load_val_o == $past(rst_val_r)))
    else $error("qualified clear event did not load reset value");
  cont_every_a: assert property ((qual_evt && cfg.cont) |=> pos_load_o == $past(cfg.clear_en))
    else $error("continuous mode missed an event");
  idle_no_action_a: assert property ((qual_evt && !cfg.cont && !cfg.once) |=> !pos_load_o)
    else $error("action without continuous or one-shot");
  once_self_clear_a: assert property ((act_evt && cfg.once && !cfg.cont) |=> !cfg_r[EIDX_B_ONCE])
    else $error("one-shot bit not cleared");
  polarity_level_a: assert property ((cfg.index_sensitivity == EIDX_SENS_LEVEL && cfg.ignore_ab) |-> raw_evt == (n_s == cfg.pol_high))
    else $error("level mode polarity wrong");
  level_hold_a: assert property ((cfg.index_sensitivity == EIDX_SENS_LEVEL && ab_ok && n_active) |=> index_event_o)
    else $error("level event not held");
  // Both-edge mode may legally see two edges in a row, so only single-edge modes are held to one cycle.
  edge_pulse_a: assert property ((cfg.index_sensitivity inside {EIDX_SENS_RISE, EIDX_SENS_FALL} && qual_evt)
    |=> (!qual_evt || cfg.index_sensitivity == EIDX_SENS_LEVEL))
    else $error("edge event longer than one cycle");
  a_gate_a: assert property ((!cfg.ignore_ab && a_s != cfg.a_level) |-> !qual_evt)
    else $error("event with wrong A level");
  b_gate_a: assert property ((!cfg.ignore_ab && b_s != cfg.b_level) |-> !qual_evt)
    else $error("event with wrong B level");
  ab_ignored_a: assert property ((cfg.ignore_ab && raw_evt) |-> qual_evt)
    else $error("A and B not ignored");
  latch_capture_a: assert property ((act_evt && cfg.latch_en) |=> latch_r == $past(enc_pos_i))
    else $error("latch did not capture position");
  // Both stages must have left reset before the pin can be seen at the output.
  sync_delay_a: assert property (($past(reset_n_i) && $past(reset_n_i, 2)) |-> n_s == $past(enc_n_i, 2))
    else $error("index sync delay not two cycles");

  level_cov: cover property (cfg.index_sensitivity == EIDX_SENS_LEVEL && qual_evt);
  both_cov: cover property (cfg.index_sensitivity == EIDX_SENS_BOTH && qual_evt);
  once_cov: cover property (act_evt && cfg.once ##1 !cfg_r[EIDX_B_ONCE]);
  latch_cov: cover property (act_evt && cfg.latch_en && cfg.clear_en);

endmodule // eidx_top

// >>> test/eidx_enc_model.sv
// Behavioural incremental encoder that drives the A, B and index pins.
// Assumes the bench calls drive() from its clocked thread.
`timescale 1ns/1ps
module eidx_enc_model (
  // Clock.
  input  wire logic clk_i,
  // Encoder pins.
  output logic      enc_a_o,
  output logic      enc_b_o,
  output logic      enc_n_o
);
  // The pins are push-pull and always driven, so they have no released state.
  initial
  begin
    enc_a_o = 1'b0;
    enc_b_o = 1'b0;
    enc_n_o = 1'b0;
  end

  // Levels change just after a rising edge and then hold until the next call.
  task automatic drive(input logic a, input logic b, input logic n);
    @(posedge clk_i);
    enc_a_o <= a;
    enc_b_o <= b;
    enc_n_o <= n;
  endtask
endmodule // eidx_enc_model

// >>> test/eidx_top_tb.sv
// Self-checking bench for the index event block.
// Assumes the encoder model in eidx_enc_model.sv.
`timescale 1ns/1ps
module eidx_top_tb;
  import eidx_pkg::*;
  logic        clk_i, reset_n_i, wr_i, rd_i, ea, eb, en, ld_o, ev_o, dec_o;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata, pos_i, ldv;
  int          error_cnt = 0;
  int          n_compared = 0;

  eidx_top i_eidx_top (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .enc_a_i(ea), .enc_b_i(eb), .enc_n_i(en),
    .enc_pos_i(pos_i), .pos_load_o(ld_o), .pos_load_val_o(ldv), .index_event_o(ev_o),
    .decimal_mode_o(dec_o));
  eidx_enc_model i_eidx_enc_model (.clk_i(clk_i), .enc_a_o(ea), .enc_b_o(eb), .enc_n_o(en));

  // Clock at 10 MHz.
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cnt(input string nm, input int e, input int g);
    n_compared++;
    if (g != e)
    begin
      error_cnt++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is taken there.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask

  // Settles the pins, flips the index once, then counts event and load cycles.
  task automatic apply_n(input logic a, b, n0, n1, output int ev, output int ld);
    i_eidx_enc_model.drive(a, b, n0);
    repeat (5) @(posedge clk_i);
    i_eidx_enc_model.drive(a, b, n1);
    ev = 0;
    ld = 0;
    repeat (8)
    begin
      @(negedge clk_i);
      ev += int'(ev_o === 1'b1);
      ld += int'(ld_o === 1'b1);
    end
  endtask

  task automatic t_reset();
    logic [31:0] d;
    rd(EIDX_CFG_OFS, d);
    chk32("cfg_reset", EIDX_CFG_RST, d);
    rd(8'h55, d);
    chk32("unmapped", 32'h0000_0000, d);
    wr(EIDX_POS_OFS, 32'h0000_00FF);
    rd(EIDX_POS_OFS, d);
    chk32("pos_ro", pos_i, d);
    wr(EIDX_RESET_VAL_OFS, 32'h0000_0F0F);
    rd(EIDX_RESET_VAL_OFS, d);
    chk32("rst_val", 32'h0000_0F0F, d);
    rd(EIDX_STATUS_OFS, d);
    chk32("status", 32'h0000_0000, d);
  endtask

  task automatic t_decimal();
    wr(EIDX_CFG_OFS, 32'h0000_0001);
    repeat (2) @(negedge clk_i);
    chk32("decimal", 32'h0000_0001, {31'h0, dec_o});
  endtask

  // One-shot with rising edge: one load, bit 3 cleared, then no second load.
  task automatic t_once();
    int ev, ld;
    logic [31:0] d;
    wr(EIDX_RESET_VAL_OFS, 32'h1234_5678);
    wr(EIDX_CFG_OFS, 32'h0000_023A);
    repeat (2) @(negedge clk_i);
    chk32("load_val", 32'h1234_5678, ldv);
    apply_n(1'b0, 1'b0, 1'b0, 1'b1, ev, ld);
    chk_cnt("once_ev", 1, ev);
    chk_cnt("once_ld", 1, ld);
    rd(EIDX_CFG_OFS, d);
    chk32("once_clr", 32'h0000_0232, d);
    apply_n(1'b0, 1'b0, 1'b0, 1'b1, ev, ld);
    chk_cnt("once_rep", 0, ld);
  endtask

  // Continuous, low-active, trigger into inactive level.
  task automatic t_cont_fall();
    int ev, ld;
    wr(EIDX_CFG_OFS, 32'h0000_0246);
    repeat (2)
    begin
      apply_n(1'b0, 1'b0, 1'b0, 1'b1, ev, ld);
      chk_cnt("fall_ld", 1, ld);
    end
  endtask

  task automatic t_both();
    int ev, ld;
    wr(EIDX_CFG_OFS, 32'h0000_0276);
    apply_n(1'b0, 1'b0, 1'b0, 1'b1, ev, ld);
    chk_cnt("both_up", 1, ev);
    apply_n(1'b0, 1'b0, 1'b1, 1'b0, ev, ld);
    chk_cnt("both_dn", 1, ev);
  endtask

  task automatic t_level();
    int ev, ld;
    wr(EIDX_CFG_OFS, 32'h0000_0216);
    apply_n(1'b0, 1'b0, 1'b0, 1'b1, ev, ld);
    chk_cnt("lvl_long", 5, ev);
    chk_cnt("lvl_ld", 5, ld);
    chk_cnt("lvl_held", 1, int'(ev_o === 1'b1));
  endtask

  // A high and B low needed, then B high once b_level is set.
  task automatic t_ab();
    int ev, ld;
    wr(EIDX_CFG_OFS, 32'h0000_00B6);
    apply_n(1'b0, 1'b0, 1'b0, 1'b1, ev, ld);
    chk_cnt("a_low", 0, ev);
    apply_n(1'b1, 1'b0, 1'b0, 1'b1, ev, ld);
    chk_cnt("a_ok", 1, ev);
    apply_n(1'b1, 1'b1, 1'b0, 1'b1, ev, ld);
    chk_cnt("b_high", 0, ev);
    wr(EIDX_CFG_OFS, 32'h0000_01B6);
    apply_n(1'b1, 1'b1, 1'b0, 1'b1, ev, ld);
    chk_cnt("b_ok", 1, ev);
  endtask

  // Latch without clear: position copied, counter never loaded.
  task automatic t_latch();
    int ev, ld;
    logic [31:0] d;
    pos_i <= 32'hCAFE_0001;
    // Clear stays off here, as software must keep it in closed-loop use.
    wr(EIDX_CFG_OFS, 32'h0000_0634);
    apply_n(1'b0, 1'b0, 1'b0, 1'b1, ev, ld);
    chk_cnt("no_clr", 0, ld);
    rd(EIDX_LATCH_OFS, d);
    chk32("latch", 32'hCAFE_0001, d);
  endtask

  task automatic final_report();
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    final_report();
  end

  initial
  begin
    {reset_n_i, wr_i, rd_i, addr_i, wdata_i} = '0;
    pos_i = 32'h0000_0ABC;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_decimal();
    t_once();
    t_cont_fall();
    t_both();
    t_level();
    t_ab();
    t_latch();
    final_report();
  end
endmodule // eidx_top_tb
